//--- tsw_pkg.sv
// Purpose: Shared constants and types for the switch map and output control block.
// Assumes: 16-bit host bus, 32 streams of 512 channels, 40 MHz core clock.
// Notes: The slot rate is scaled so that one slot has room for all 32 streams.
package tsw_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int STREAM_W = 5;
  localparam int CHAN_W = 9;
  localparam int ENTRY_W = 14;
  localparam int BYTE_W = 8;
  localparam logic [CHAN_W-1:0] CHAN_LAST = 9'h1FF;
  localparam logic [STREAM_W-1:0] STREAM_LAST = 5'h1F;
  localparam logic [ENTRY_W-1:0] ENTRY_LAST = 14'h3FFF;

  localparam logic [1:0] SEL_DATA_MEM = 2'h3;
  localparam logic [1:0] SEL_CONN_MEM = 2'h2;
  localparam logic [1:0] SEL_REGS = 2'h1;
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_ALIGN = 4'h1;
  localparam int REG_OFFSET_FLAG = 13;

  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_IND_SELECT = 14;
  localparam int BIT_IND_POLARITY = 13;
  localparam int BIT_ALL_IND = 12;
  localparam int BIT_BLOCK_ARM = 9;
  localparam int BIT_FILL_HI = 8;
  localparam int BIT_FILL_LO = 7;
  localparam int BIT_FILL_GO = 6;
  localparam int BIT_STANDBY = 5;
  localparam int BIT_EVAL_START = 4;
  localparam logic [15:0] CTRL_WMASK = 16'hF3F0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;

  localparam int CM_MODE_HI = 15;
  localparam int CM_MODE_LO = 14;

  typedef enum logic [1:0] {
    TSW_MODE_VARIABLE = 2'h0,
    TSW_MODE_CONSTANT = 2'h1,
    TSW_MODE_PROCESSOR = 2'h2,
    TSW_MODE_HIZ = 2'h3
  } tsw_mode_e;

  typedef enum logic [1:0] {
    TSW_ST_IDLE = 2'h1,
    TSW_ST_SWITCH = 2'h2
  } tsw_state_e;

  localparam logic [1:0] BANK_LAST = 2'h2;
  localparam logic [5:0] SLOT_CYCLES = 6'h30;
  localparam logic [5:0] SLOT_LAST = SLOT_CYCLES - 6'h01;
  localparam int FIFO_DEPTH = 8;
  localparam int TX_WORD_W = 1 + STREAM_W + CHAN_W + BYTE_W;

  localparam int CLK_PERIOD_NS = 25;
  localparam int SOFT_RESET_MIN_NS = 20;
  localparam int SOFT_RESET_MIN_CYC_RAW = (SOFT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_RESET_MIN_CYC = (SOFT_RESET_MIN_CYC_RAW < 1) ? 1 : SOFT_RESET_MIN_CYC_RAW;

  localparam int PIN_SYNC_W = 36;
  localparam logic [35:0] PIN_SYNC_RESET = 36'h700000000;
endpackage

//--- tsw_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Full and empty come from a registered occupancy count.
`timescale 1ns/100ps
module tsw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] COUNT_FULL = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != COUNT_FULL);
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

//--- tsw_switch_ctrl.sv
// Purpose: Host map, control register, per-channel delay selection and output drive.
// Assumes: Host strobes are asynchronous pins; receive bytes come from core_clk logic.
// Notes: Each slot walks all 32 output streams into an 8-word FIFO; a full FIFO stalls slots.
// Contract
// - Constant delay gives 512 plus (512 minus n) plus m slots from input to output.
// - Variable delay gives 512-(n-m) slots when m<=n+2, otherwise m-n slots.
// - Delay select 11 forces that channel high impedance whatever the pin and standby.
// - Other selects drive unless both drive pin and standby bit are zero.
// - Address 11 reads data memory, 10 reads or writes connection memory, stream/channel below.
// - Address 01 decodes control, alignment and eight offset registers from bits 13:10.
// - Control register bit layout is fixed; bits 11, 10 and 3:0 read zero.
// - Soft reset bit clears control, offsets, fill and slot timing but not the FIFO or tx register; host must clear it.
// - Select 00 variable, 01 constant, 10 outputs low connection byte, 11 three-states.
// - Constant delay data written in frame n is read in frame n+2.
`timescale 1ns/100ps
module tsw_switch_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_data_in,
  output logic [15:0] bus_data_out,
  output logic bus_data_oe,
  input wire logic output_drive_pin,
  input wire logic rx_valid,
  input wire logic [4:0] rx_stream,
  input wire logic [7:0] rx_data,
  input wire logic [15:0] frame_align_status,
  output logic [8:0] slot_index,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [4:0] tx_stream,
  output logic [8:0] tx_channel,
  output logic [7:0] tx_data,
  output logic tx_oe,
  output logic [15:0] switch_control_out,
  output logic [127:0] frame_offset_out
);
  logic [35:0] pin_meta_reg;
  logic [35:0] pin_sync_reg;
  logic wr_act_prev_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] offs_reg [8];
  logic [15:0] cmem [16384];
  logic [7:0] dmem [65536];
  logic fill_active_reg;
  logic [13:0] fill_idx_reg;
  logic [5:0] div_cnt_reg;
  logic [8:0] slot_reg;
  logic [1:0] bank_reg;
  tsw_pkg::tsw_state_e state_reg;
  logic [4:0] ost_reg;
  logic [15:0] rd_data_reg;
  logic rd_oe_reg;
  logic tx_valid_reg;
  logic [22:0] tx_word_reg;

  logic drive_sync;
  logic cs_act;
  logic wr_act;
  logic rd_act;
  logic [15:0] h_addr;
  logic [15:0] h_wdata;
  logic wr_evt;
  logic soft_rst;
  logic ctrl_wr;
  logic fill_start;
  logic fill_done;
  logic tick;
  logic [1:0] prev_bank;
  logic [1:0] old_bank;
  logic [15:0] cm_word;
  tsw_pkg::tsw_mode_e mode;
  logic [8:0] src_chan;
  logic late_slot;
  logic [1:0] rd_bank;
  logic [7:0] push_data;
  logic push_oe;
  logic push_valid;
  logic push_ready;
  logic [22:0] fifo_out_word;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [15:0] rd_mux;

  // Pins cross into the core clock through two flip-flops.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta_reg <= tsw_pkg::PIN_SYNC_RESET;
      pin_sync_reg <= tsw_pkg::PIN_SYNC_RESET;
      wr_act_prev_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= {output_drive_pin, bus_cs_n, bus_rd_n, bus_wr_n, bus_addr, bus_data_in};
      pin_sync_reg <= pin_meta_reg;
      wr_act_prev_reg <= wr_act;
    end
  end

  assign drive_sync = pin_sync_reg[35];
  assign cs_act = !pin_sync_reg[34];
  assign rd_act = cs_act && !pin_sync_reg[33];
  assign wr_act = cs_act && !pin_sync_reg[32];
  assign h_addr = pin_sync_reg[31:16];
  assign h_wdata = pin_sync_reg[15:0];
  assign wr_evt = wr_act && !wr_act_prev_reg;
  assign soft_rst = ctrl_reg[tsw_pkg::BIT_SOFT_RESET];
  assign ctrl_wr = wr_evt && (h_addr[15:14] == tsw_pkg::SEL_REGS) &&
                   (h_addr[13:10] == tsw_pkg::REG_CONTROL);
  assign fill_start = ctrl_wr && !soft_rst && h_wdata[tsw_pkg::BIT_FILL_GO] &&
                      !ctrl_reg[tsw_pkg::BIT_FILL_GO] && h_wdata[tsw_pkg::BIT_BLOCK_ARM];
  assign fill_done = fill_active_reg && (fill_idx_reg == tsw_pkg::ENTRY_LAST);

  // While soft reset is set only the soft reset bit takes a write; a host write beats the
  // completion clear of the fill bits.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg <= tsw_pkg::CTRL_RESET;
    end
    else if (ctrl_wr && soft_rst)
    begin
      ctrl_reg <= {h_wdata[tsw_pkg::BIT_SOFT_RESET], 15'h0000};
    end
    else if (ctrl_wr)
    begin
      ctrl_reg <= h_wdata & tsw_pkg::CTRL_WMASK;
    end
    else if (soft_rst)
    begin
      ctrl_reg[14:0] <= 15'h0000;
    end
    else if (fill_done)
    begin
      ctrl_reg[tsw_pkg::BIT_BLOCK_ARM:tsw_pkg::BIT_FILL_GO] <= 4'h0;
    end
  end

  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_offs
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          offs_reg[i] <= tsw_pkg::OFFSET_RESET;
        end
        else if (soft_rst)
        begin
          offs_reg[i] <= tsw_pkg::OFFSET_RESET;
        end
        else if (wr_evt && (h_addr[15:14] == tsw_pkg::SEL_REGS) &&
                 h_addr[tsw_pkg::REG_OFFSET_FLAG] && (h_addr[12:10] == 3'(i)))
        begin
          offs_reg[i] <= h_wdata;
        end
      end
      assign frame_offset_out[16*i +: 16] = offs_reg[i];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fill_active_reg <= 1'b0;
      fill_idx_reg <= '0;
    end
    else if (soft_rst || fill_done)
    begin
      fill_active_reg <= 1'b0;
      fill_idx_reg <= '0;
    end
    else if (fill_start)
    begin
      fill_active_reg <= 1'b1;
      fill_idx_reg <= '0;
    end
    else if (fill_active_reg)
    begin
      fill_idx_reg <= fill_idx_reg + 14'h0001;
    end
  end

  // Block fill owns the write port; host writes to connection memory are dropped meanwhile.
  always_ff @(posedge core_clk)
  begin
    if (fill_active_reg)
    begin
      cmem[fill_idx_reg] <= {ctrl_reg[tsw_pkg::BIT_FILL_HI:tsw_pkg::BIT_FILL_LO], 14'h0000};
    end
    else if (wr_evt && !soft_rst && (h_addr[15:14] == tsw_pkg::SEL_CONN_MEM))
    begin
      cmem[h_addr[13:0]] <= h_wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rx_valid && !soft_rst)
    begin
      dmem[{bank_reg, rx_stream, slot_reg}] <= rx_data;
    end
  end

  // Slot time base; a slot does not end until every stream of the last slot is queued.
  assign tick = (div_cnt_reg == tsw_pkg::SLOT_LAST) && (state_reg == tsw_pkg::TSW_ST_IDLE);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_cnt_reg <= '0;
      slot_reg <= '0;
      bank_reg <= '0;
    end
    else if (soft_rst)
    begin
      div_cnt_reg <= '0;
      slot_reg <= '0;
      bank_reg <= '0;
    end
    else if (tick)
    begin
      div_cnt_reg <= '0;
      slot_reg <= slot_reg + 9'h001;
      if (slot_reg == tsw_pkg::CHAN_LAST)
      begin
        bank_reg <= (bank_reg == tsw_pkg::BANK_LAST) ? 2'h0 : bank_reg + 2'h1;
      end
    end
    else if (div_cnt_reg != tsw_pkg::SLOT_LAST)
    begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  assign prev_bank = (bank_reg == 2'h0) ? tsw_pkg::BANK_LAST : bank_reg - 2'h1;
  assign old_bank = (bank_reg == tsw_pkg::BANK_LAST) ? 2'h0 : bank_reg + 2'h1;
  assign cm_word = cmem[{ost_reg, slot_reg}];
  assign mode = tsw_pkg::tsw_mode_e'(cm_word[tsw_pkg::CM_MODE_HI:tsw_pkg::CM_MODE_LO]);
  assign src_chan = cm_word[8:0];
  assign late_slot = ({1'b0, slot_reg} > ({1'b0, src_chan} + 10'h002));

  always_comb
  begin
    rd_bank = prev_bank;
    case (mode)
      tsw_pkg::TSW_MODE_CONSTANT: rd_bank = old_bank;
      tsw_pkg::TSW_MODE_VARIABLE: rd_bank = late_slot ? bank_reg : prev_bank;
      default: rd_bank = prev_bank;
    endcase
  end

  assign push_data = (mode == tsw_pkg::TSW_MODE_PROCESSOR) ? cm_word[7:0] :
                     dmem[{rd_bank, cm_word[13:0]}];
  assign push_oe = (mode != tsw_pkg::TSW_MODE_HIZ) &&
                   (drive_sync || ctrl_reg[tsw_pkg::BIT_STANDBY]);
  assign push_valid = (state_reg == tsw_pkg::TSW_ST_SWITCH);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= tsw_pkg::TSW_ST_IDLE;
      ost_reg <= '0;
    end
    else if (soft_rst)
    begin
      state_reg <= tsw_pkg::TSW_ST_IDLE;
      ost_reg <= '0;
    end
    else
    begin
      case (state_reg)
        tsw_pkg::TSW_ST_IDLE:
        begin
          if (tick)
          begin
            state_reg <= tsw_pkg::TSW_ST_SWITCH;
            ost_reg <= '0;
          end
        end
        tsw_pkg::TSW_ST_SWITCH:
        begin
          if (push_ready)
          begin
            ost_reg <= ost_reg + 5'h01;
            if (ost_reg == tsw_pkg::STREAM_LAST)
            begin
              state_reg <= tsw_pkg::TSW_ST_IDLE;
            end
          end
        end
        default:
        begin
          state_reg <= tsw_pkg::TSW_ST_IDLE;
        end
      endcase
    end
  end

  tsw_fifo #(
    .WIDTH(tsw_pkg::TX_WORD_W),
    .DEPTH(tsw_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data({push_oe, ost_reg, slot_reg, push_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_word)
  );

  assign fifo_out_ready = !tx_valid_reg || tx_ready;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_valid_reg <= 1'b0;
      tx_word_reg <= '0;
    end
    else if (fifo_out_ready)
    begin
      tx_valid_reg <= fifo_out_valid;
      tx_word_reg <= fifo_out_word;
    end
  end

  always_comb
  begin
    rd_mux = 16'h0000;
    case (h_addr[15:14])
      tsw_pkg::SEL_DATA_MEM: rd_mux = {8'h00, dmem[{prev_bank, h_addr[13:0]}]};
      tsw_pkg::SEL_CONN_MEM: rd_mux = cmem[h_addr[13:0]];
      tsw_pkg::SEL_REGS:
      begin
        if (h_addr[tsw_pkg::REG_OFFSET_FLAG])
        begin
          rd_mux = offs_reg[h_addr[12:10]];
        end
        else if (h_addr[13:10] == tsw_pkg::REG_CONTROL)
        begin
          rd_mux = ctrl_reg;
        end
        else if (h_addr[13:10] == tsw_pkg::REG_ALIGN)
        begin
          rd_mux = frame_align_status;
        end
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data_reg <= 16'h0000;
      rd_oe_reg <= 1'b0;
    end
    else
    begin
      rd_data_reg <= rd_mux;
      rd_oe_reg <= rd_act;
    end
  end

  assign bus_data_out = rd_data_reg;
  assign bus_data_oe = rd_oe_reg;
  assign slot_index = slot_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_oe = tx_word_reg[22];
  assign tx_stream = tx_word_reg[21:17];
  assign tx_channel = tx_word_reg[16:8];
  assign tx_data = tx_word_reg[7:0];
  assign switch_control_out = ctrl_reg;

  a_hiz_forces_off: assert property (@(posedge core_clk) disable iff (!rstn)
    push_valid && (mode == tsw_pkg::TSW_MODE_HIZ) |-> !push_oe)
    else $error("high impedance channel was driven");
  a_standby_drive_on: assert property (@(posedge core_clk) disable iff (!rstn)
    push_valid && (mode != tsw_pkg::TSW_MODE_HIZ) |->
    (push_oe == (drive_sync || ctrl_reg[tsw_pkg::BIT_STANDBY])))
    else $error("drive enable disagrees with pin and standby");
  a_const_two_frames: assert property (@(posedge core_clk) disable iff (!rstn)
    push_valid && (mode == tsw_pkg::TSW_MODE_CONSTANT) |->
    (rd_bank != bank_reg) && (rd_bank != prev_bank))
    else $error("constant delay read wrong frame");
  a_var_same_frame: assert property (@(posedge core_clk) disable iff (!rstn)
    push_valid && (mode == tsw_pkg::TSW_MODE_VARIABLE) &&
    ({1'b0, slot_reg} > {1'b0, src_chan} + 10'h002) |->
    rd_bank == bank_reg)
    else $error("late variable slot not read from current frame");
  a_var_prev_frame: assert property (@(posedge core_clk) disable iff (!rstn)
    push_valid && (mode == tsw_pkg::TSW_MODE_VARIABLE) && (src_chan >= slot_reg) |->
    rd_bank == prev_bank)
    else $error("early variable slot not read from previous frame");
  a_proc_byte_out: assert property (@(posedge core_clk) disable iff (!rstn)
    push_valid && push_ready && (mode == tsw_pkg::TSW_MODE_PROCESSOR) |=>
    (u_fifo.count_reg != '0) &&
    (u_fifo.mem[$past(u_fifo.wr_ptr_reg)][7:0] == $past(cm_word[7:0])))
    else $error("processor byte not queued");
  a_slot_wrap_bank: assert property (@(posedge core_clk) disable iff (!rstn)
    tick && !soft_rst && (slot_reg == tsw_pkg::CHAN_LAST) |=>
    (slot_reg == 9'h000) && (bank_reg != $past(bank_reg)))
    else $error("frame did not wrap after slot 511");
  a_soft_clears_all: assert property (@(posedge core_clk) disable iff (!rstn)
    soft_rst |=> (ctrl_reg[14:0] == 15'h0000) && !fill_active_reg && (slot_reg == 9'h000))
    else $error("soft reset left state behind");
  a_ctrl_zero_bits: assert property (@(posedge core_clk) disable iff (!rstn)
    ##1 (ctrl_reg[11:10] == 2'h0) && (ctrl_reg[3:0] == 4'h0))
    else $error("unused control bits not zero");
  a_fill_clears_bits: assert property (@(posedge core_clk) disable iff (!rstn)
    fill_done && !ctrl_wr |=> (ctrl_reg[tsw_pkg::BIT_BLOCK_ARM:tsw_pkg::BIT_FILL_GO] == 4'h0))
    else $error("fill completion did not clear its bits");
  a_read_ctrl_map: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_act && (h_addr[15:10] == 6'h10) |=> bus_data_out == $past(ctrl_reg))
    else $error("control register read returned wrong data");

  c_const_push: cover property (@(posedge core_clk) disable iff (!rstn)
    push_valid && push_ready && (mode == tsw_pkg::TSW_MODE_CONSTANT));
  c_var_late: cover property (@(posedge core_clk) disable iff (!rstn)
    push_valid && push_ready && (mode == tsw_pkg::TSW_MODE_VARIABLE) && late_slot);
  c_fill_done: cover property (@(posedge core_clk) disable iff (!rstn) fill_done);
  c_tx_stall: cover property (@(posedge core_clk) disable iff (!rstn)
    push_valid && !push_ready);
endmodule

//--- tsw_host_model.sv
// Purpose: Host processor model driving the RAM-style register bus.
// Assumes: Pins change just after a falling clock edge.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/100ps
module tsw_host_model (
  input wire logic core_clk,
  output logic bus_cs_n,
  output logic bus_rd_n,
  output logic bus_wr_n,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_data_in,
  input wire logic [15:0] bus_data_out,
  input wire logic bus_data_oe
);
  initial
  begin
    bus_cs_n = 1'b1;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    bus_addr = 16'h0000;
    bus_data_in = 16'h0000;
  end

  // Address and data settle through the synchronisers before the strobe falls.
  task automatic open_cycle(input logic [15:0] a, input logic [15:0] d);
    bus_addr = a;
    bus_data_in = d;
    repeat (3) @(negedge core_clk);
    bus_cs_n = 1'b0;
  endtask

  // The gap outlasts the resynchronisation and any 20 ns soft reset hold.
  task automatic close_cycle();
    bus_cs_n = 1'b1;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    bus_addr = ~bus_addr;
    bus_data_in = ~bus_data_in;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    open_cycle(a, d);
    bus_wr_n = 1'b0;
    repeat (5) @(negedge core_clk);
    close_cycle();
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    open_cycle(a, ~bus_data_in);
    bus_rd_n = 1'b0;
    repeat (6) @(negedge core_clk);
    d = (bus_data_oe === 1'b1) ? bus_data_out : 16'hXXXX;
    close_cycle();
  endtask
endmodule

//--- tb.sv
// Purpose: Self-checking bench for the switch map and output control block.
// Assumes: Slots last 48 cycles; the host model drives the register pins.
// Notes: Words leaving the block are logged per stream and channel, then compared.
`timescale 1ns/100ps
module tb;
  logic core_clk, rstn, bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe, output_drive_pin;
  logic rx_valid, tx_valid, tx_ready, tx_oe;
  logic [15:0] bus_addr, bus_data_in, bus_data_out, frame_align_status, switch_control_out;
  logic [4:0] rx_stream, tx_stream;
  logic [7:0] rx_data, tx_data;
  logic [8:0] slot_index, tx_channel, last_slot;
  logic [127:0] frame_offset_out;
  logic [7:0] seen_data [16384];
  logic seen_oe [16384];
  logic [15:0] rv;
  logic [15:0] wv [8];
  logic [13:0] ix;
  int frame_cnt, cycles, mismatches, samples_checked;
  int frame_base;
  localparam logic [15:0] CTRL_A = 16'h4000;

  tsw_switch_ctrl DUT (.core_clk, .rstn, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_addr,
    .bus_data_in, .bus_data_out, .bus_data_oe, .output_drive_pin, .rx_valid, .rx_stream,
    .rx_data, .frame_align_status, .slot_index, .tx_valid, .tx_ready, .tx_stream,
    .tx_channel, .tx_data, .tx_oe, .switch_control_out, .frame_offset_out);
  tsw_host_model host (.core_clk, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_addr,
    .bus_data_in, .bus_data_out, .bus_data_oe);

  always #12.5 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    last_slot <= slot_index;
    if (slot_index === 9'h000 && last_slot === 9'h1FF)
      frame_cnt <= frame_cnt + 1;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      seen_data[{tx_stream, tx_channel}] <= tx_data;
      seen_oe[{tx_stream, tx_channel}] <= tx_oe;
    end
    if (cycles == 90000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // The consumer stalls about one cycle in eight.
  always @(negedge core_clk)
    tx_ready <= ($urandom % 8) != 0;

  function automatic int var_delay(input int n, input int m);
    return (m <= n + 2) ? 512 - (n - m) : m - n;
  endfunction

  function automatic logic exp_oe(input logic [1:0] mode, input logic drv, input logic sby);
    return mode != 2'h3 && (drv || sby);
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_word(input logic [13:0] i, input logic [7:0] d, input logic oe);
    chk("tx data", {8'h00, d}, {8'h00, seen_data[i]});
    chk("tx drive", {15'h0000, oe}, {15'h0000, seen_oe[i]});
  endtask

  task automatic wait_abs(input int target);
    while ((frame_cnt - frame_base) * 512 + int'(slot_index) < target)
      @(negedge core_clk);
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    void'($urandom(55));
    core_clk = 1'b0;
    rstn = 1'b0;
    output_drive_pin = 1'b1;
    rx_valid = 1'b0;
    rx_stream = 5'h00;
    rx_data = 8'h00;
    frame_align_status = 16'($urandom);
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    host.rd(CTRL_A, rv);
    chk("control reset", tsw_pkg::CTRL_RESET, rv);
    host.wr(CTRL_A, 16'h7D3F);
    host.rd(CTRL_A | 16'h03FF, rv);
    chk("control", 16'h7D3F & tsw_pkg::CTRL_WMASK, rv);
    chk("control out", 16'h7D3F & tsw_pkg::CTRL_WMASK, switch_control_out);
    host.rd(16'h4555, rv);
    chk("alignment", frame_align_status, rv);
    host.rd(16'h4800, rv);
    chk("unmapped", 16'h0000, rv);
    for (int i = 0; i < 8; i++)
    begin
      wv[i] = 16'($urandom);
      host.wr(16'h6000 | 16'(i << 10) | 16'($urandom % 1024), wv[i]);
    end
    for (int i = 0; i < 8; i++)
    begin
      host.rd(16'h6000 | 16'(i << 10), rv);
      chk("offset", wv[i], rv);
      chk("offset out", wv[i], frame_offset_out[16*i +: 16]);
    end
    for (int i = 0; i < 6; i++)
    begin
      ix = {5'($urandom), 1'b1, 8'($urandom)};
      wv[i] = 16'($urandom);
      host.wr({tsw_pkg::SEL_CONN_MEM, ix}, wv[i]);
      host.rd({tsw_pkg::SEL_CONN_MEM, ix}, rv);
      chk("connection", wv[i], rv);
    end
    host.wr({tsw_pkg::SEL_CONN_MEM, 5'h07, 9'h03C}, {2'h0, 5'h03, 9'h028});
    host.wr({tsw_pkg::SEL_CONN_MEM, 5'h08, 9'h029}, {2'h0, 5'h03, 9'h028});
    host.wr({tsw_pkg::SEL_CONN_MEM, 5'h09, 9'h046}, {2'h1, 5'h03, 9'h028});
    for (int k = 0; k < 4; k++)
    begin
      wv[k] = 16'($urandom);
      host.wr({tsw_pkg::SEL_CONN_MEM, 5'h00, 9'(89 + 2 * k)}, {2'h2, 6'h00, wv[k][7:0]});
      host.wr({tsw_pkg::SEL_CONN_MEM, 5'h01, 9'(89 + 2 * k)}, {2'h3, wv[k][13:0]});
    end
    while (slot_index !== 9'h028)
      @(negedge core_clk);
    frame_base = frame_cnt;
    rx_valid = 1'b1;
    rx_stream = 5'h03;
    rx_data = 8'($urandom);
    @(negedge core_clk);
    rx_valid = 1'b0;
    wait_abs(40 + var_delay(40, 60) + 2);
    chk_word({5'h07, 9'h03C}, rx_data, exp_oe(2'h0, 1'b1, 1'b1));
    wait_abs(40 + var_delay(40, 41) + 2);
    chk_word({5'h08, 9'h029}, rx_data, exp_oe(2'h0, 1'b1, 1'b1));
    host.rd({tsw_pkg::SEL_DATA_MEM, 5'h03, 9'h028}, rv);
    chk("data memory", {8'h00, rx_data}, rv);
    host.wr({tsw_pkg::SEL_DATA_MEM, 5'h03, 9'h028}, ~rv);
    host.rd({tsw_pkg::SEL_DATA_MEM, 5'h03, 9'h028}, rv);
    chk("data memory", {8'h00, rx_data}, rv);
    for (int k = 0; k < 4; k++)
    begin
      wait_abs(600 + 2 * k);
      output_drive_pin = k[1];
      host.wr(CTRL_A, k[0] ? 16'h0020 : 16'h0000);
    end
    wait_abs(610);
    for (int k = 0; k < 4; k++)
    begin
      chk_word({5'h00, 9'(89 + 2 * k)}, wv[k][7:0], exp_oe(2'h2, k[1], k[0]));
      chk("hiz drive", 16'(exp_oe(2'h3, k[1], k[0])), 16'(seen_oe[{5'h01, 9'(89 + 2 * k)}]));
    end
    wait_abs(40 + 512 + (512 - 40) + 70 + 2);
    chk_word({5'h09, 9'h046}, rx_data, exp_oe(2'h1, 1'b1, 1'b1));
    host.wr(CTRL_A, 16'h8000);
    host.rd(CTRL_A, rv);
    chk("soft reset control", 16'h8000, rv);
    chk("soft reset slot", 16'h0000, {7'h00, slot_index});
    host.wr(16'h6400, 16'h5A5A);
    host.wr(CTRL_A, 16'h0000);
    host.rd(16'h6400, rv);
    chk("offset after soft reset", tsw_pkg::OFFSET_RESET, rv);
    host.rd(CTRL_A, rv);
    chk("control after soft reset", tsw_pkg::CTRL_RESET, rv);
    host.wr(CTRL_A, 16'h0340);
    repeat (16400) @(negedge core_clk);
    host.rd(CTRL_A, rv);
    chk("control after fill", 16'h0000, rv);
    host.rd({tsw_pkg::SEL_CONN_MEM, 5'h09, 9'h046}, rv);
    chk("connection after fill", 16'h8000, rv);
    wrap_up();
  end
endmodule
